/* hdl/rpi_params.svh */
`ifndef RPI_PARAMS_SVH
`define RPI_PARAMS_SVH

// Register indices; byte address is four times the index
`define RPI_IDX_OFS   14'h2278
`define RPI_STS_OFS   14'h227e
`define RPI_IDX_ADDR  {`RPI_IDX_OFS, 2'h0}
`define RPI_STS_ADDR  {`RPI_STS_OFS, 2'h0}

// Reset and fixed read values
`define RPI_PEND_RST  4'hf
`define RPI_CODE_RST  2'h0
`define RPI_RATE_RST  1'h1
`define RPI_RSV_RD    3'h7
`define RPI_IDX_B32   2'h3
`define RPI_RD_PAD    24'h0

`endif

/* hdl/rpi_pkg.sv */
package rpi_pkg;

    // Event codes in index order
    typedef enum logic [1:0] {
        RPI_EV_MODEM_READY,
        RPI_EV_TX_DONE,
        RPI_EV_RX_BEGIN,
        RPI_EV_RX_DONE
    } rpi_event_e;

    typedef logic [3:0] rpi_evvec_t;

endpackage

/* hdl/rpi_event_report.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rpi_params.svh"

// Functional notes
// - The index field is two bits naming the pending event: 0 ready, 1 tx done, 2 rx begin, 3 rx done.
// - Events that arrive together are queued and shown one at a time in processing order.
// - Reading the index field removes the reported event so the next queued one shows.
// - The pending field has four bits, one per source, in the same order as the index codes.
// - A firing source drives its pending bit to zero; zero means pending, one means idle.
// - After reset the pending bits are all one and the index field is zero.
// - Status bit 4 always equals the extended-rate flag held in the index register.
// - The extended-rate flag captures the received packet rate at the receive-done event.
module rpi_event_report
    import rpi_pkg::*;
#(
    parameter int QDEPTH = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        modem_ready_event,
    input  wire logic        transmit_done_event,
    input  wire logic        receive_begin_event,
    input  wire logic        receive_done_event,
    input  wire logic        rx_rate_ext
);

    localparam int AW = $clog2(QDEPTH);

    generate
        if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_chk
            $error("QDEPTH must be a power of two of at least 2");
        end
    endgenerate

    rpi_evvec_t  ev;
    logic        setup;
    logic        access;
    logic        hit_idx;
    logic        hit_sts;
    logic        rd_pop;
    logic        sts_wr;
    logic        empty;
    logic        full;
    logic        push;
    rpi_event_e  pick_code;
    rpi_evvec_t  pick_mask;
    logic [1:0]  head;
    logic [AW:0] count;
    rpi_evvec_t  wr_set;

    rpi_evvec_t  arrived_q;
    rpi_evvec_t  arrived_d;
    rpi_evvec_t  pend_n_q;
    rpi_evvec_t  pend_n_d;
    logic        rate_q;
    logic        rate_d;
    logic [AW:0] wr_ptr_q;
    logic [AW:0] wr_ptr_d;
    logic [AW:0] rd_ptr_q;
    logic [AW:0] rd_ptr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic        idx_live_q;
    logic        idx_live_d;
    logic [1:0]  mem_q [QDEPTH];
    logic [1:0]  mem_d [QDEPTH];

    // Event sources gathered by index code
    assign ev = {receive_done_event, receive_begin_event,
                 transmit_done_event, modem_ready_event};

    // APB decode, zero wait states
    assign setup   = psel & ~penable;
    assign access  = psel & penable;
    assign hit_idx = (paddr == `RPI_IDX_ADDR);
    assign hit_sts = (paddr == `RPI_STS_ADDR);
    assign pready  = 1'h1;
    assign pslverr = access & ~(hit_idx | hit_sts);
    assign prdata  = prdata_q;

    assign sts_wr = access & pwrite & hit_sts & pstrb[0];

    // Queue state
    assign count = wr_ptr_q - rd_ptr_q;
    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full  = (count == (AW + 1)'(QDEPTH));
    assign head  = empty ? `RPI_CODE_RST : mem_q[rd_ptr_q[AW-1:0]];

    // Pop only what the setup cycle showed, never a later push
    assign rd_pop = access & ~pwrite & hit_idx & idx_live_q;

    // Lowest waiting source goes first
    always_comb begin
        pick_code = RPI_EV_MODEM_READY;
        pick_mask = 4'h0;
        for (int k = 3; k >= 0; k--) begin
            if (arrived_q[k]) begin
                pick_code = rpi_event_e'(k[1:0]);
                pick_mask = rpi_evvec_t'(4'h1 << k);
            end
        end
    end

    assign push = (|arrived_q) & ~full;

    // Waiting arrivals; a fresh event is kept even while its old copy is taken
    always_comb begin
        arrived_d = (arrived_q & ~(push ? pick_mask : 4'h0)) | ev;
    end

    always_comb begin
        wr_ptr_d = wr_ptr_q + (AW + 1)'(push);
        rd_ptr_d = rd_ptr_q + (AW + 1)'(rd_pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arrived_q <= 4'h0;
            wr_ptr_q  <= '0;
            rd_ptr_q  <= '0;
        end else begin
            arrived_q <= arrived_d;
            wr_ptr_q  <= wr_ptr_d;
            rd_ptr_q  <= rd_ptr_d;
        end
    end

    // Queue entries
    generate
        for (genvar i = 0; i < QDEPTH; i++) begin : g_ent
            assign mem_d[i] = (push && wr_ptr_q[AW-1:0] == AW'(i)) ? pick_code : mem_q[i];

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    mem_q[i] <= `RPI_CODE_RST;
                end else begin
                    mem_q[i] <= mem_d[i];
                end
            end
        end
    endgenerate

    // Pending bits: event clears to zero and wins over a software set
    always_comb begin
        pend_n_d = pend_n_q;
        if (sts_wr) begin
            pend_n_d = pend_n_d | pwdata[3:0];
        end
        pend_n_d = pend_n_d & ~ev;
    end

    // Rate flag taken at receive done
    always_comb begin
        rate_d = rate_q;
        if (receive_done_event) begin
            rate_d = rx_rate_ext;
        end
    end

    // Read data captured in the setup cycle
    always_comb begin
        prdata_d   = prdata_q;
        idx_live_d = idx_live_q;
        if (setup) begin
            idx_live_d = ~pwrite & hit_idx & ~empty;
        end
        if (setup && !pwrite) begin
            if (hit_idx) begin
                prdata_d = {`RPI_RD_PAD, `RPI_RSV_RD, rate_q, `RPI_IDX_B32, head};
            end else if (hit_sts) begin
                prdata_d = {`RPI_RD_PAD, `RPI_RSV_RD, rate_q, pend_n_q};
            end else begin
                prdata_d = 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_n_q <= `RPI_PEND_RST;
            rate_q   <= `RPI_RATE_RST;
            prdata_q <= 32'h0;
            idx_live_q <= 1'h0;
        end else begin
            pend_n_q <= pend_n_d;
            rate_q   <= rate_d;
            prdata_q <= prdata_d;
            idx_live_q <= idx_live_d;
        end
    end

    // Checks
    assign wr_set = sts_wr ? (pwdata[3:0] & ~ev) : 4'h0;

    default clocking cb @(posedge pclk);
    endclocking

    default disable iff (!presetn);

    property p_pend_fire;
        (|ev) |=> ((pend_n_q & $past(ev)) == 4'h0);
    endproperty
    a_pend_fire: assert property (p_pend_fire) else $error("fired source not pending");

    property p_pend_idle;
        (wr_set != 4'h0)
            |=> ((pend_n_q & $past(wr_set)) == $past(wr_set));
    endproperty
    a_pend_idle: assert property (p_pend_idle) else $error("pending bit not returned to idle");

    property p_pend_hold;
        (!sts_wr && ev == 4'h0) |=> $stable(pend_n_q);
    endproperty
    a_pend_hold: assert property (p_pend_hold) else $error("pending bits changed without cause");

    property p_reset_vals;
        $rose(presetn) |-> (pend_n_q == 4'hf && head == 2'h0 && empty);
    endproperty
    a_reset_vals: assert property (disable iff (1'b0) p_reset_vals) else $error("bad reset values");

    property p_pop;
        rd_pop |=> (rd_ptr_q == (AW + 1)'($past(rd_ptr_q) + 1));
    endproperty
    a_pop: assert property (p_pop) else $error("index read did not pop");

    property p_no_pop;
        !rd_pop |=> $stable(rd_ptr_q);
    endproperty
    a_no_pop: assert property (p_no_pop) else $error("queue popped without index read");

    property p_pick;
        push |-> (arrived_q[pick_code] && ((arrived_q & ((4'h1 << pick_code) - 4'h1)) == 4'h0));
    endproperty
    a_pick: assert property (p_pick) else $error("queued out of order");

    property p_keep;
        (full && (|arrived_q)) |=> ((arrived_q & $past(arrived_q)) == $past(arrived_q));
    endproperty
    a_keep: assert property (p_keep) else $error("waiting event lost while full");

    property p_rd_idx;
        (setup && !pwrite && hit_idx) ##1 access
            |-> (prdata[1:0] == $past(head) && prdata[4] == $past(rate_q));
    endproperty
    a_rd_idx: assert property (p_rd_idx) else $error("index read wrong");

    property p_mirror;
        (setup && !pwrite && hit_sts) |=> (prdata[4] == $past(rate_q) && prdata[3:0] == $past(pend_n_q));
    endproperty
    a_mirror: assert property (p_mirror) else $error("status bit 4 not mirrored");

    property p_rate;
        receive_done_event |=> (rate_q == $past(rx_rate_ext));
    endproperty
    a_rate: assert property (p_rate) else $error("rate flag not captured");

    property p_rsv;
        (setup && !pwrite && (hit_idx || hit_sts)) |=> (prdata[7:5] == 3'h7);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not ones");

    property p_pop_empty;
        (setup && !pwrite && hit_idx && empty) |=> (!rd_pop && prdata[1:0] == 2'h0);
    endproperty
    a_pop_empty: assert property (p_pop_empty) else $error("empty index read popped or showed a code");

    property p_ev_wait;
        (|ev) |=> ((arrived_q & $past(ev)) == $past(ev));
    endproperty
    a_ev_wait: assert property (p_ev_wait) else $error("fired event not waiting for the queue");

    property p_count;
        count <= (AW + 1)'(QDEPTH);
    endproperty
    a_count: assert property (p_count) else $error("queue count above depth");

    property p_rate_hold;
        !receive_done_event |=> $stable(rate_q);
    endproperty
    a_rate_hold: assert property (p_rate_hold) else $error("rate flag changed without receive done");

    property p_slverr;
        (access && !pwrite && !(hit_idx || hit_sts)) |-> (pslverr && prdata == 32'h0);
    endproperty
    a_slverr: assert property (p_slverr) else $error("unmapped read not refused");

    c_two_events: cover property ((ev[0] && ev[2]) ##[1:4] (count == 2));
    c_pop:        cover property (rd_pop ##1 !empty);
    c_sts_write:  cover property (sts_wr && pend_n_q != 4'hf);
    c_full:       cover property (full && (|arrived_q));
    c_late_push:  cover property ((setup && !pwrite && hit_idx && empty) ##1 (access && !empty));

endmodule

`default_nettype wire

/* testbench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rpi_params.svh"

module tb_top;
    import rpi_pkg::*;

    logic        pclk                = 1'b0;
    logic        presetn             = 1'b0;
    logic        psel                = 1'b0;
    logic        penable             = 1'b0;
    logic        pwrite              = 1'b0;
    logic [15:0] paddr               = 16'h0000;
    logic [31:0] pwdata              = 32'h0000_0000;
    logic [3:0]  pstrb               = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        modem_ready_event   = 1'b0;
    logic        transmit_done_event = 1'b0;
    logic        receive_begin_event = 1'b0;
    logic        receive_done_event  = 1'b0;
    logic        rx_rate_ext         = 1'b0;
    integer      seed                = 91;
    integer      rnd;
    int          fails               = 0;
    int          tests_run           = 0;
    logic [32:0] exp_q[$];
    logic        rate                = 1'b1;
    logic [3:0]  pend                = 4'hf;
    logic [1:0]  ev;

    rpi_event_report i_dut (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .pstrb               (pstrb),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .modem_ready_event   (modem_ready_event),
        .transmit_done_event (transmit_done_event),
        .receive_begin_event (receive_begin_event),
        .receive_done_event  (receive_done_event),
        .rx_rate_ext         (rx_rate_ext)
    );

    always #4 pclk = ~pclk;

    task automatic check(input logic [32:0] seen, input logic [32:0] expv);
        tests_run++;
        if (seen !== expv) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic summarize();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Setup, access, wait for pready, then release
    task automatic apb(input logic [15:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            fails++;
            summarize();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [32:0] expv);
        exp_q.push_back(expv);
        apb(a, 1'b0, 32'h0000_0000, 4'hf);
    endtask

    function automatic logic [32:0] sts_v();
        return {25'h0, 3'h7, rate, pend};
    endfunction

    function automatic logic [32:0] idx_v(input logic [1:0] c);
        return {25'h0, 3'h7, rate, 2'h3, c};
    endfunction

    // Pulse events for one cycle, then move the rate input away
    task automatic fire(input logic [3:0] e, input logic r);
        @(posedge pclk);
        {receive_done_event, receive_begin_event, transmit_done_event, modem_ready_event} <= e;
        rx_rate_ext <= r;
        @(posedge pclk);
        {receive_done_event, receive_begin_event, transmit_done_event, modem_ready_event} <= 4'h0;
        rx_rate_ext <= ~r;
        pend = pend & ~e;
        if (e[3]) begin
            rate = r;
        end
        repeat (6) @(posedge pclk);
    endtask

    // Each completed read is compared against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready && !pwrite) begin
            if (exp_q.size() == 0) begin
                check(33'h1_0000_0000, 33'h0);
            end else begin
                check({pslverr, prdata}, exp_q.pop_front());
            end
        end
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`RPI_STS_ADDR, sts_v());
        rd(`RPI_IDX_ADDR, idx_v(2'h0));
        fire(4'hf, 1'b0);
        rd(`RPI_STS_ADDR, sts_v());
        fire(4'hf, 1'b1);
        rd(`RPI_STS_ADDR, sts_v());
        for (int c = 0; c < 8; c++) begin
            rd(`RPI_IDX_ADDR, idx_v(c[1:0]));
        end
        rd(`RPI_IDX_ADDR, idx_v(2'h0));
        apb(`RPI_STS_ADDR, 1'b1, 32'h0000_00ff, 4'he);
        rd(`RPI_STS_ADDR, sts_v());
        rnd = $random(seed);
        apb(`RPI_STS_ADDR, 1'b1, rnd, 4'hf);
        pend = pend | rnd[3:0];
        rd(`RPI_STS_ADDR, sts_v());
        apb(`RPI_IDX_ADDR, 1'b1, 32'h0000_0003, 4'hf);
        rd(`RPI_IDX_ADDR, idx_v(2'h0));
        rd(16'h89e4, {1'b1, 32'h0});
        apb(`RPI_STS_ADDR, 1'b1, 32'h0000_000f, 4'hf);
        pend = 4'hf;
        for (int i = 0; i < 8; i++) begin
            rnd = $random(seed);
            ev  = rnd[1:0];
            fire(4'h1 << ev, rnd[4]);
            rd(`RPI_STS_ADDR, sts_v());
            rd(`RPI_IDX_ADDR, idx_v(ev));
            apb(`RPI_STS_ADDR, 1'b1, 32'h1 << ev, 4'hf);
            pend = 4'hf;
            rd(`RPI_STS_ADDR, sts_v());
        end
        repeat (4) @(posedge pclk);
        check(33'(exp_q.size()), 33'h0);
        summarize();
    end
endmodule

`default_nettype wire
